// ===== rtl/cab_pkg.sv
// package: encodings, field positions and widths for the add/logic/branch slice
`default_nettype none
package cab_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned PC_W = 21;
  // opcode patterns
  localparam logic [7:0] OPC_ADD_IMM = 8'h0f;
  localparam logic [7:0] OPC_AND_IMM = 8'h0b;
  localparam logic [5:0] OPC_ADD_REG = 6'h09;
  localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
  localparam logic [5:0] OPC_AND_REG = 6'h05;
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;
  localparam logic [3:0] OPC_COND_BR_HI = 4'he;
  localparam logic [4:0] OPC_BR_ALWAYS = 5'h1a;
  localparam logic [3:0] CND_NONZERO = 4'h1;
  localparam logic [3:0] CND_CARRY = 4'h2;
  localparam logic [3:0] CND_NO_CARRY = 4'h3;
  localparam logic [3:0] CND_NO_OVERFLOW = 4'h5;
  localparam logic [3:0] CND_NEGATIVE = 4'h6;
  localparam logic [3:0] CND_POSITIVE = 4'h7;
  // instruction field positions
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned ACC_BIT = 8;
  localparam int unsigned BIDX_LSB = 9;
  // status flag positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_DC = 1;
  localparam int unsigned FLG_Z = 2;
  localparam int unsigned FLG_OV = 3;
  localparam int unsigned FLG_N = 4;
  // access bank split: access offsets below 0x60 map to bank 0, the rest to the top bank
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HIGH_BANK = 4'hf;
  localparam logic [3:0] ACC_LOW_BANK = 4'h0;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLG_RST = 5'h00;
  // four phases of one instruction cycle
  typedef enum logic [1:0] {
    CAB_Q1 = 2'b00,
    CAB_Q2 = 2'b01,
    CAB_Q3 = 2'b11,
    CAB_Q4 = 2'b10
  } cab_phase_t;
  // operation class
  typedef enum logic [2:0] {
    CAB_NOP = 3'h0,
    CAB_ADD = 3'h1,
    CAB_AND = 3'h2,
    CAB_BCLR = 3'h3,
    CAB_BR = 3'h4
  } cab_op_t;
endpackage : cab_pkg
`default_nettype wire

// ===== rtl/cab_dec_if.sv
// interface: decoded instruction fields between decoder and execute core
`default_nettype none
interface cab_dec_if;
  import cab_pkg::*;
  cab_op_t op;
  logic use_carry;
  logic use_imm;
  logic to_file;
  logic set_arith;
  logic [3:0] cond;
  logic br_always;
  logic [PC_W-1:0] disp;
  modport dec (output op, use_carry, use_imm, to_file, set_arith, cond, br_always, disp);
  modport exe (input op, use_carry, use_imm, to_file, set_arith, cond, br_always, disp);
endinterface : cab_dec_if
`default_nettype wire

// ===== rtl/cab_decoder.sv
// decoder: instruction word to operation class, destination and displacement
`default_nettype none
module cab_decoder
  import cab_pkg::*;
(
  // instruction
  input wire logic [15:0] instr_in,
  // decoded fields
  cab_dec_if.dec dec
);
  // sign-extend an offset and double it into a byte displacement
  function automatic logic [PC_W-1:0] cab_disp(input logic [10:0] n, input logic wide);
    logic [PC_W-1:0] ext;
    ext = wide ? {{(PC_W-11){n[10]}}, n} : {{(PC_W-8){n[7]}}, n[7:0]};
    return {ext[PC_W-2:0], 1'b0};
  endfunction : cab_disp

  // combinational decode of the upper bits
  always_comb begin
    dec.op = CAB_NOP;
    dec.use_carry = 1'b0;
    dec.use_imm = 1'b0;
    dec.to_file = instr_in[DEST_BIT];
    dec.set_arith = 1'b0;
    dec.cond = instr_in[11:8];
    dec.br_always = 1'b0;
    dec.disp = cab_disp(instr_in[10:0], 1'b0);
    if (instr_in[15:8] == OPC_ADD_IMM) begin
      dec.op = CAB_ADD;
      dec.use_imm = 1'b1;
      dec.to_file = 1'b0;
      dec.set_arith = 1'b1;
    end else if (instr_in[15:8] == OPC_AND_IMM) begin
      dec.op = CAB_AND;
      dec.use_imm = 1'b1;
      dec.to_file = 1'b0;
    end else if (instr_in[15:10] == OPC_ADD_REG || instr_in[15:10] == OPC_ADD_CARRY) begin
      dec.op = CAB_ADD;
      dec.use_carry = (instr_in[15:10] == OPC_ADD_CARRY);
      dec.set_arith = 1'b1;
    end else if (instr_in[15:10] == OPC_AND_REG) begin
      dec.op = CAB_AND;
    end else if (instr_in[15:12] == OPC_BIT_CLEAR) begin
      dec.op = CAB_BCLR;
      dec.to_file = 1'b1;
    end else if (instr_in[15:12] == OPC_COND_BR_HI) begin
      // only the six documented conditions; others fall through as no operation
      if (instr_in[11:8] == CND_NONZERO || instr_in[11:8] == CND_CARRY || instr_in[11:8] == CND_NO_CARRY ||
          instr_in[11:8] == CND_NO_OVERFLOW || instr_in[11:8] == CND_NEGATIVE ||
          instr_in[11:8] == CND_POSITIVE) begin
        dec.op = CAB_BR;
      end
    end else if (instr_in[15:11] == OPC_BR_ALWAYS) begin
      dec.op = CAB_BR;
      dec.br_always = 1'b1;
      dec.disp = cab_disp(instr_in[10:0], 1'b1);
    end
  end
endmodule : cab_decoder
`default_nettype wire

// ===== rtl/cab_alu.sv
// alu: add with carry/digit carry/overflow, and, bit clear
`default_nettype none
module cab_alu
  import cab_pkg::*;
(
  // operands
  input wire cab_op_t op_in,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic [DATA_W-1:0] opnd_in,
  input wire logic carry_in,
  input wire logic [2:0] bit_idx_in,
  // result
  output logic [DATA_W-1:0] res_out,
  output logic c_out,
  output logic dc_out,
  output logic ov_out
);
  logic [DATA_W:0] sum;
  logic [4:0] low_sum;

  // one adder serves both add forms; carry-in is zero for plain add
  always_comb begin
    sum = {1'b0, acc_in} + {1'b0, opnd_in} + {{DATA_W{1'b0}}, carry_in};
    low_sum = {1'b0, acc_in[3:0]} + {1'b0, opnd_in[3:0]} + {4'h0, carry_in};
    c_out = sum[DATA_W];
    dc_out = low_sum[4];
    ov_out = (acc_in[DATA_W-1] == opnd_in[DATA_W-1]) && (sum[DATA_W-1] != acc_in[DATA_W-1]);
    unique case (op_in)
      CAB_ADD: res_out = sum[DATA_W-1:0];
      CAB_AND: res_out = acc_in & opnd_in;
      CAB_BCLR: res_out = opnd_in & ~(8'h01 << bit_idx_in);
      default: res_out = opnd_in;
    endcase
  end
endmodule : cab_alu
`default_nettype wire

// ===== rtl/cab_core.sv
// top: four-phase execute slice for add, and, bit clear and relative branches
//
// Overview of operation
// - add immediate to accumulator, all five flags
// - add register, optionally plus carry, all flags
// - destination bit 0 accumulator, 1 file register
// - access bit 0 selects fixed access bank
// - and immediate into accumulator, negative/zero only
// - and register to destination, negative/zero only
// - bit clear zeroes one bit, flags kept
// - branch offset signed, doubled to bytes
// - taken target is branch address plus two plus 2n
// - not taken one cycle, taken adds idle cycle
// - branch on carry set or clear
// - branch on negative set or clear
// - branch on overflow clear, flags kept
// - branch on zero clear, flags kept
// - unconditional branch always taken, two cycles
//
// Timing
// one instruction cycle is four clocks, phase_out walking 00, 01, 11, 10
// a word is taken on the edge that leaves the first phase when it is valid
// and the block is not in the idle cycle that follows a taken branch
// the operand is latched leaving the second phase, the alu result leaving
// the third; accumulator, status, the file write strobe and a taken branch's pc
// change together on the edge that leaves the fourth phase; pc steps by two leaving the first
// a taken branch costs one extra cycle whose four phases are empty; a word
// offered in it is dropped and the surrounding core must offer it again
// limitation: there is no result forwarding, so file_rdata_in must be steady
// for the whole second phase, and a write is only seen by the next read
// trade-off: the file address is formed in the first phase from the raw word,
// so bank_select_register_in is sampled there and not later
//
// Implementation choices: the address-and-strobe port and the address map.
`default_nettype none
module cab_core
  import cab_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // instruction fetch
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  // bank select register from the surrounding core
  input wire logic [3:0] bank_select_register_in,
  // data memory read data
  input wire logic [DATA_W-1:0] file_rdata_in,
  // data memory port
  output logic [ADDR_W-1:0] file_addr_out,
  output logic file_rd_out,
  output logic file_we_out,
  output logic [DATA_W-1:0] file_wdata_out,
  // architectural state
  output logic [DATA_W-1:0] acc_out,
  output logic [4:0] status_out,
  output logic [PC_W-1:0] pc_out,
  // phase and cycle markers
  output logic [1:0] phase_out,
  output logic instr_take_out,
  output logic idle_cycle_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // phase sequencer and the idle cycle after a taken branch
  cab_phase_t ph_q, ph_d;
  logic idle_q, idle_d;

  // the word in flight and what has been worked out for it
  logic [15:0] ir_q, ir_d;
  logic live_q, live_d;
  logic [DATA_W-1:0] opnd_q, opnd_d;
  logic [DATA_W-1:0] res_q, res_d;
  logic [4:0] alu_flg_q, alu_flg_d;
  logic take_q, take_d;

  // architectural state owned by this slice
  logic [DATA_W-1:0] acc_q, acc_d;
  logic [4:0] flg_q, flg_d;
  logic [PC_W-1:0] pc_q, pc_d;

  // data memory port, registered so the memory sees clean strobes
  logic [ADDR_W-1:0] fa_q, fa_d;
  logic frd_q, frd_d;
  logic fwe_q, fwe_d;
  logic [DATA_W-1:0] fwd_q, fwd_d;

  // combinational results of the alu and the branch test
  logic [DATA_W-1:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_ov;
  logic cond_true;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  // the decoder looks at the latched word, so its fields are steady from the
  // second phase on while instr_in is already free to change
  cab_dec_if dec_bus ();
  cab_decoder u_dec (
    .instr_in(ir_q),
    .dec(dec_bus.dec)
  );

  // form a file address from the access bit, bank select and 8-bit offset
  // access bit clear: low offsets reach bank 0, high offsets the top bank
  function automatic logic [ADDR_W-1:0] cab_faddr(input logic a, input logic [3:0] bank_select_register, input logic [7:0] f);
    logic [3:0] bank;
    bank = f < ACC_SPLIT ? ACC_LOW_BANK : ACC_HIGH_BANK;
    if (a) begin
      bank = bank_select_register;
    end
    return {bank, f};
  endfunction : cab_faddr

  // ------------------------------------------------------------
  // execute
  // ------------------------------------------------------------
  // carry-in is gated here so a plain add never sees the carry flag
  cab_alu u_alu (
    .op_in(dec_bus.op),
    .acc_in(acc_q),
    .opnd_in(opnd_q),
    .carry_in(dec_bus.use_carry & flg_q[FLG_C]),
    .bit_idx_in(ir_q[BIDX_LSB +: 3]),
    .res_out(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .ov_out(alu_ov)
  );

  // branch condition from current status
  // codes the decoder did not accept never reach here as a branch
  always_comb begin
    cond_true = dec_bus.br_always;
    if (!dec_bus.br_always) begin
      unique case (dec_bus.cond)
        CND_CARRY: cond_true = flg_q[FLG_C];
        CND_NO_CARRY: cond_true = !flg_q[FLG_C];
        CND_NEGATIVE: cond_true = flg_q[FLG_N];
        CND_POSITIVE: cond_true = !flg_q[FLG_N];
        CND_NO_OVERFLOW: cond_true = !flg_q[FLG_OV];
        CND_NONZERO: cond_true = !flg_q[FLG_Z];
        default: cond_true = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // phase sequencer and datapath next state; strobes default low so
  // each pulse lasts exactly one clock
  always_comb begin
    ph_d = ph_q;
    ir_d = ir_q;
    live_d = live_q;
    idle_d = idle_q;
    opnd_d = opnd_q;
    res_d = res_q;
    alu_flg_d = alu_flg_q;
    take_d = take_q;
    acc_d = acc_q;
    flg_d = flg_q;
    pc_d = pc_q;
    fa_d = fa_q;
    frd_d = 1'b0;
    fwe_d = 1'b0;
    fwd_d = fwd_q;
    unique case (ph_q)
      CAB_Q1: begin
        ph_d = CAB_Q2;
        // decode; an idle cycle after a taken branch ignores the fetch
        live_d = instr_valid_in & !idle_q;
        if (instr_valid_in && !idle_q) begin
          ir_d = instr_in;
          pc_d = pc_q + PC_STEP; // counter moves to next word on fetch
        end
        // the address comes from the raw word so it is out before the read phase
        fa_d = cab_faddr(instr_in[ACC_BIT], bank_select_register_in, instr_in[7:0]);
        frd_d = instr_valid_in & !idle_q;
      end
      CAB_Q2: begin
        ph_d = CAB_Q3;
        // operand read: immediate or file register
        // literal forms drop the memory data although the read was issued
        opnd_d = dec_bus.use_imm ? ir_q[7:0] : file_rdata_in;
      end
      CAB_Q3: begin
        // process data; flags are staged and committed in the fourth phase
        ph_d = CAB_Q4;
        res_d = alu_res;
        alu_flg_d[FLG_C] = alu_c;
        alu_flg_d[FLG_DC] = alu_dc;
        alu_flg_d[FLG_OV] = alu_ov;
        alu_flg_d[FLG_Z] = (alu_res == ACC_RST);
        alu_flg_d[FLG_N] = alu_res[DATA_W-1];
        take_d = live_q && dec_bus.op == CAB_BR && cond_true;
      end
      CAB_Q4: begin
        ph_d = CAB_Q1;
        // a taken branch opens the idle cycle that runs its four phases empty
        idle_d = take_q;
        // write back: accumulator, status, a taken branch's pc and file strobe move together
        take_d = 1'b0;
        if (live_q) begin
          unique case (dec_bus.op)
            CAB_ADD, CAB_AND: begin
              // the destination bit picks file register or accumulator
              if (dec_bus.to_file) begin
                fwe_d = 1'b1;
                fwd_d = res_q;
              end else begin
                acc_d = res_q;
              end
              // and touches only zero and negative; add also the arithmetic flags
              flg_d[FLG_Z] = alu_flg_q[FLG_Z];
              flg_d[FLG_N] = alu_flg_q[FLG_N];
              if (dec_bus.set_arith) begin
                flg_d[FLG_C] = alu_flg_q[FLG_C];
                flg_d[FLG_DC] = alu_flg_q[FLG_DC];
                flg_d[FLG_OV] = alu_flg_q[FLG_OV];
              end
            end
            CAB_BCLR: begin
              // one bit cleared in a read-modify-write; status is left alone
              fwe_d = 1'b1;
              fwd_d = res_q;
            end
            CAB_BR: begin
              // pc already holds branch address plus two
              if (take_q) begin
                pc_d = pc_q + dec_bus.disp;
              end
            end
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // reset loads constants only, so its release needs no ordering
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // sequencer and word in flight
      ph_q <= CAB_Q1;
      ir_q <= 16'h0000;
      live_q <= 1'b0;
      idle_q <= 1'b0;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      alu_flg_q <= FLG_RST;
      take_q <= 1'b0;
      // architectural state
      acc_q <= ACC_RST;
      flg_q <= FLG_RST;
      pc_q <= '0;
      // memory port
      fa_q <= '0;
      frd_q <= 1'b0;
      fwe_q <= 1'b0;
      fwd_q <= 8'h00;
    end else begin
      // sequencer and word in flight
      ph_q <= ph_d;
      ir_q <= ir_d;
      live_q <= live_d;
      idle_q <= idle_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      alu_flg_q <= alu_flg_d;
      take_q <= take_d;
      // architectural state
      acc_q <= acc_d;
      flg_q <= flg_d;
      pc_q <= pc_d;
      // memory port
      fa_q <= fa_d;
      frd_q <= frd_d;
      fwe_q <= fwe_d;
      fwd_q <= fwd_d;
    end
  end

  // ------------------------------------------------------------
  // outputs straight from flip-flops
  // ------------------------------------------------------------
  assign file_addr_out = fa_q;
  assign file_rd_out = frd_q;
  assign file_we_out = fwe_q;
  assign file_wdata_out = fwd_q;
  assign acc_out = acc_q;
  assign status_out = flg_q;
  assign pc_out = pc_q;
  assign phase_out = ph_q;
  assign instr_take_out = live_q;
  assign idle_cycle_out = idle_q;
endmodule : cab_core
`default_nettype wire

// ===== bench/cab_core_checker.sv
// checker: port-level timing and hold properties of the add/logic/branch slice
`default_nettype none
module cab_core_checker
  import cab_pkg::*;
(
  // clock, reset and inputs
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [15:0] instr_in,
  input wire logic instr_valid_in,
  input wire logic [3:0] bank_select_register_in,
  input wire logic [DATA_W-1:0] file_rdata_in,
  // outputs under watch
  input wire logic [ADDR_W-1:0] file_addr_out,
  input wire logic file_rd_out,
  input wire logic file_we_out,
  input wire logic [DATA_W-1:0] file_wdata_out,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic [4:0] status_out,
  input wire logic [PC_W-1:0] pc_out,
  input wire logic [1:0] phase_out,
  input wire logic instr_take_out,
  input wire logic idle_cycle_out
);
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // a word counts only in a live first phase; the idle cycle swallows it
  wire logic take = phase_out == 2'b00 && instr_valid_in && !idle_cycle_out;
  a_phase_walk: assert property (phase_out == 2'b00 |=> phase_out == 2'b01 ##1 phase_out == 2'b11
    ##1 phase_out == 2'b10 ##1 phase_out == 2'b00) else $error("phase order broken");
  a_pc_step: assert property (take |=> pc_out == $past(pc_out) + PC_STEP)
    else $error("pc not advanced by two after take");
  a_read_pulse: assert property (take |=> file_rd_out ##1 !file_rd_out)
    else $error("operand read pulse missing in second phase");
  a_flags_kept: assert property ((take && (instr_in[15:12] == 4'h9 || instr_in[15:12] == 4'he))
    |-> ##4 status_out == $past(status_out, 4)) else $error("flags changed by clear or branch");
  a_idle_span: assert property ($rose(idle_cycle_out) |-> phase_out == 2'b00 ##0 idle_cycle_out [*4]
    ##1 !idle_cycle_out) else $error("idle cycle not one full cycle");
  a_idle_quiet: assert property (idle_cycle_out |-> !file_rd_out && !file_we_out)
    else $error("memory access in idle cycle");
  a_idle_pc_hold: assert property (idle_cycle_out && phase_out != 2'b00 |-> $stable(pc_out))
    else $error("pc moved in idle cycle");
  a_write_phase: assert property (file_we_out |-> phase_out == 2'b00 ##1 !file_we_out)
    else $error("file write outside first phase");
  a_state_hold: assert property (phase_out != 2'b00 |-> $stable(acc_out) && $stable(status_out))
    else $error("result written mid cycle");
  a_take_mark: assert property (take |=> instr_take_out [*4])
    else $error("live marker not held for a taken word");
  a_drop_mark: assert property (phase_out == 2'b00 && !take |=> !instr_take_out)
    else $error("live marker raised for a dropped word");
  // main scenarios seen
  c_taken: cover property ($rose(idle_cycle_out));
  c_write: cover property (file_we_out);
  c_branch_carry: cover property (take && instr_in[15:12] == 4'he && status_out[FLG_C]);
endmodule : cab_core_checker

bind cab_core cab_core_checker u_chk (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .instr_in(instr_in), .instr_valid_in(instr_valid_in), .bank_select_register_in(bank_select_register_in),
  .file_rdata_in(file_rdata_in), .file_addr_out(file_addr_out), .file_rd_out(file_rd_out),
  .file_we_out(file_we_out), .file_wdata_out(file_wdata_out), .acc_out(acc_out), .status_out(status_out),
  .pc_out(pc_out), .phase_out(phase_out), .instr_take_out(instr_take_out), .idle_cycle_out(idle_cycle_out));
`default_nettype wire

// ===== bench/testbench.sv
// testbench: instruction sequences with expected accumulator, flags, pc and file writes
`default_nettype none
module testbench
  import cab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------
  // signals and device
  // ----------------
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [15:0] instr_in = 16'h0000;
  logic instr_valid_in = 1'b0;
  logic [3:0] bank_select_register_in = 4'h0;
  logic [7:0] file_rdata_in = 8'h00;
  logic [11:0] file_addr_out;
  logic file_rd_out, file_we_out, idle_cycle_out, instr_take_out;
  logic [7:0] file_wdata_out, acc_out;
  logic [4:0] status_out;
  logic [20:0] pc_out;
  logic [1:0] phase_out;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] e_acc = 8'h00, e_wd = 8'h00;
  logic [4:0] e_st = 5'h00;
  logic [20:0] e_pc = 21'h000000;
  logic [11:0] e_fa = 12'h000;
  logic e_we = 1'b0, e_fon = 1'b0, e_idle = 1'b0, e_tk = 1'b0;
  logic [3:0] cnd [6] = '{CND_CARRY, CND_NO_CARRY, CND_NEGATIVE, CND_POSITIVE, CND_NO_OVERFLOW, CND_NONZERO};
  logic [7:0] offs [6] = '{8'h7f, 8'h80, 8'h05, 8'hfb, 8'h01, 8'h00};
  logic [5:0] tk_set = 6'b001001;
  cab_core dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .instr_in(instr_in),
    .instr_valid_in(instr_valid_in), .bank_select_register_in(bank_select_register_in),
    .file_rdata_in(file_rdata_in), .file_addr_out(file_addr_out), .file_rd_out(file_rd_out),
    .file_we_out(file_we_out), .file_wdata_out(file_wdata_out), .acc_out(acc_out), .status_out(status_out),
    .pc_out(pc_out), .phase_out(phase_out), .instr_take_out(instr_take_out), .idle_cycle_out(idle_cycle_out));
  // 25 MHz core clock
  initial begin
    forever #20 core_clk_in = ~core_clk_in;
  end
  // hang guard: the sequence needs about 135 clocks
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ----------------
  // tasks
  // ----------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // results of the previous word are looked at in the next first phase, mid-cycle
  task automatic chk_all();
    @(negedge core_clk_in);
    chk(21'(acc_out), 21'(e_acc));
    chk(21'(status_out), 21'(e_st));
    chk(pc_out, e_pc);
    chk(21'(idle_cycle_out), 21'(e_idle));
    chk(21'(instr_take_out), 21'(e_tk));
    chk(21'(file_we_out), 21'(e_we));
    if (e_we) chk(21'(file_wdata_out), 21'(e_wd));
    if (e_fon) chk(21'(file_addr_out), 21'(e_fa));
  endtask : chk_all
  // present one word at the edge that opens a first phase, then expect its outcome
  task automatic run(input logic [15:0] w, input logic [7:0] rd, input logic [7:0] a, input logic [4:0] s,
                     input logic [7:0] wd, input logic [11:0] fa, input logic tk, input logic [10:0] n);
    instr_in <= w;
    file_rdata_in <= rd;
    instr_valid_in <= 1'b1;
    chk_all();
    repeat (4) @(posedge core_clk_in);
    e_acc = a;
    e_st = s;
    e_wd = wd;
    e_fa = fa;
    e_fon = w[15:12] == 4'h1 || w[15:12] == 4'h2 || w[15:12] == 4'h9;
    e_we = w[15:12] == 4'h9 || (e_fon && w[DEST_BIT]);
    e_idle = tk;
    e_tk = 1'b1;
    e_pc = e_pc + PC_STEP + (tk ? {{9{n[10]}}, n, 1'b0} : 21'h000000);
  endtask : run
  // a word offered in the idle cycle must be dropped
  task automatic skip();
    instr_in <= 16'h0fff;
    chk_all();
    repeat (4) @(posedge core_clk_in);
    e_idle = 1'b0;
    e_tk = 1'b0;
  endtask : skip
  task automatic br(input logic [3:0] c, input logic [7:0] n, input logic tk);
    run({OPC_COND_BR_HI, c, n}, 8'h00, e_acc, e_st, e_wd, e_fa, tk, {{3{n[7]}}, n});
    if (tk) skip();
  endtask : br
  // ----------------
  // sequence
  // ----------------
  initial begin
    repeat (16) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    bank_select_register_in <= 4'h5;
    run(16'h0f15, 8'h00, 8'h15, 5'h00, 8'h00, 12'h000, 1'b0, 11'h000);
    run(16'h0ff0, 8'h00, 8'h05, 5'h01, 8'h00, 12'h000, 1'b0, 11'h000);
    run(16'h2010, 8'h7a, 8'h80, 5'h1a, 8'h00, 12'h010, 1'b0, 11'h000);
    run(16'h2780, 8'h80, 8'h80, 5'h0d, 8'h00, 12'h580, 1'b0, 11'h000);
    run(16'h0bc3, 8'h00, 8'h80, 5'h19, 8'h00, 12'h000, 1'b0, 11'h000);
    run(16'h1670, 8'h7f, 8'h80, 5'h0d, 8'h00, 12'hf70, 1'b0, 11'h000);
    bank_select_register_in <= 4'h3;
    run(16'h9f22, 8'hc7, 8'h80, 5'h0d, 8'h47, 12'h322, 1'b0, 11'h000);
    for (int i = 0; i < 6; i++) br(cnd[i], offs[i], tk_set[i]);
    run(16'h0f01, 8'h00, 8'h81, 5'h10, 8'h00, 12'h000, 1'b0, 11'h000);
    for (int i = 0; i < 6; i++) br(cnd[i], offs[i], !tk_set[i]);
    run({OPC_BR_ALWAYS, 11'h3ff}, 8'h00, e_acc, e_st, e_wd, e_fa, 1'b1, 11'h3ff);
    skip();
    run(16'h0000, 8'h00, e_acc, e_st, e_wd, e_fa, 1'b0, 11'h000);
    chk_all();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
